// [rtl/dsm_pkg.sv]
// Constants, types and decode functions for the DS3 envelope mapper
package dsm_pkg;
    // Frame and envelope geometry
    localparam logic [3:0] LAST_ROW     = 4'h8;   // Nine rows
    localparam logic [6:0] FR_LAST_COL  = 7'h59;  // 90 frame columns
    localparam logic [6:0] SPE_LAST_COL = 7'h56;  // 87 envelope columns
    localparam logic [6:0] TOH_COLS     = 7'h03;  // Transport overhead
    localparam logic [3:0] PTR_ROW      = 4'h3;   // Row of pointer bytes
    localparam logic [6:0] H1_COL       = 7'h00;
    localparam logic [6:0] H2_COL       = 7'h01;
    localparam logic [9:0] EC_LAST      = 10'h30E; // 783 capacity bytes
    localparam logic [5:0] H1_FLAGS     = 6'h18;  // Flag 0110, size 00

    // Bit layout of one payload row, 688 bits after the overhead byte
    localparam logic [9:0] OH_FIRST  = 10'h03B; // After 59 fixed stuff
    localparam logic [9:0] CTL_FIRST = 10'h03D; // Two comm bits before
    localparam logic [9:0] SO_POS    = 10'h042; // After five control
    localparam logic [2:0] CTL_MAJ   = 3'h3;    // Three of five votes

    typedef enum logic [2:0] {
        BK_FSTUFF = 3'b000,
        BK_OHC    = 3'b001,
        BK_CTL    = 3'b010,
        BK_SOPP   = 3'b011,
        BK_DATA   = 3'b100
    } dsm_bit_t;

    typedef enum logic {
        SQ_IDLE = 1'b0,
        SQ_BITS = 1'b1
    } dsm_seq_t;

    typedef struct packed {
        logic [3:0] row;
        logic [6:0] col;
    } dsm_pos_t;

    typedef struct packed {
        logic     toh;   // Byte is transport overhead
        dsm_pos_t fpos;  // Place in the frame
        dsm_pos_t spos;  // Place in the floating envelope
    } dsm_loc_t;

    localparam dsm_pos_t POS_ZERO = '{row: 4'h0, col: 7'h00};

    // Next byte position, row by row, left to right
    function automatic dsm_pos_t pos_adv(input dsm_pos_t p,
                                         input logic [6:0] last_col);
        dsm_pos_t n;
        n = p;
        if (p.col == last_col) begin
            n.col = 7'h00;
            n.row = (p.row == LAST_ROW) ? 4'h0 : p.row + 4'h1;
        end else begin
            n.col = p.col + 7'h01;
        end
        return n;
    endfunction : pos_adv

    // Kind of a payload bit from its place in the row
    function automatic dsm_bit_t bit_kind(input logic [9:0] p);
        if (p < OH_FIRST)
            return BK_FSTUFF;
        else if (p < CTL_FIRST)
            return BK_OHC;
        else if (p < SO_POS)
            return BK_CTL;
        else if (p == SO_POS)
            return BK_SOPP;
        else
            return BK_DATA;
    endfunction : bit_kind
endpackage : dsm_pkg

// [rtl/dsm_track.sv]
// Frame and floating envelope position tracker for one byte stream
`timescale 1ns/100ps
module dsm_track (
    input  wire logic         mclk,  // System clock
    input  wire logic         srst,  // Synchronous reset
    input  wire logic         step,  // One byte slot passes
    input  wire logic         fs,    // Slot is first of a frame
    input  wire logic [9:0]   ptr,   // Envelope start offset
    output dsm_pkg::dsm_loc_t loc    // Position of the last slot
);
    import dsm_pkg::*;

    dsm_pos_t   fpos_reg;
    dsm_pos_t   spos_reg;
    dsm_pos_t   fpos_next;
    logic       toh_reg;
    logic [9:0] ec_reg;
    logic [9:0] ec_next;

    assign loc = '{toh: toh_reg, fpos: fpos_reg, spos: spos_reg};

    // Capacity index restarts just after the third pointer byte
    always_comb begin
        fpos_next = fs ? POS_ZERO : pos_adv(fpos_reg, FR_LAST_COL); // [RL13]
        if (fpos_next.row == PTR_ROW && fpos_next.col == TOH_COLS)
            ec_next = 10'h000;
        else if (ec_reg == EC_LAST)
            ec_next = 10'h000;
        else
            ec_next = ec_reg + 10'h001;
    end

    // Frame position
    always_ff @(posedge mclk) begin
        if (srst) begin
            fpos_reg <= '{row: LAST_ROW, col: FR_LAST_COL};
            toh_reg  <= 1'b1;
        end else if (step) begin
            fpos_reg <= fpos_next;
            toh_reg  <= fpos_next.col < TOH_COLS; // [RL14] [RL2]
        end
    end

    // Envelope floats; a pointer match may land in any frame row
    always_ff @(posedge mclk) begin
        if (srst) begin
            ec_reg   <= EC_LAST;
            spos_reg <= '{row: LAST_ROW, col: SPE_LAST_COL};
        end else if (step && fpos_next.col >= TOH_COLS) begin // [RL2]
            ec_reg   <= ec_next;
            if (ec_next == ptr)                               // [RL3] [RL15]
                spos_reg <= POS_ZERO;
            else
                spos_reg <= pos_adv(spos_reg, SPE_LAST_COL);  // [RL1]
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    property p_spe_start;
        step && !fs && fpos_reg.col >= 7'h02 && fpos_reg.col != FR_LAST_COL
            && ec_next == ptr |=> spos_reg == POS_ZERO && ec_reg == ptr;
    endproperty
    a_spe_start: assert property (p_spe_start) // [RL3]
        else $error("envelope did not restart at pointer");

    property p_spe_bounds;
        spos_reg.col <= SPE_LAST_COL && spos_reg.row <= LAST_ROW
            && ec_reg <= EC_LAST;
    endproperty
    a_spe_bounds: assert property (p_spe_bounds) // [RL1]
        else $error("envelope position out of range");

    property p_row_starts_toh;
        step && !fs && fpos_reg.col == FR_LAST_COL
            |=> toh_reg && fpos_reg.col == 7'h00 && $stable(ec_reg);
    endproperty
    a_row_starts_toh: assert property (p_row_starts_toh) // [RL14]
        else $error("row did not open with overhead");
endmodule : dsm_track

// [rtl/dsm_mapper.sv]
// DS3 into STS-1 envelope mapper and de-mapper, bit serial per byte
//
// How it works
// [RL1] The envelope is tracked as 87 byte columns by 9 rows.
// [RL2] Every frame byte outside the overhead columns is capacity.
// [RL3] The envelope may start at any capacity byte and cross frames.
// [RL4] The first envelope column is path overhead, sent as zero here.
// [RL5] Each row has 59 fixed stuff bits, sent zero and ignored.
// [RL6] Each row carries 621 fixed DS3 data bits.
// [RL7] Each row has exactly one stuff opportunity bit.
// [RL8] The mapper picks data or stuff per row from the rate balance.
// [RL9] Five control bits per row tell how the opportunity bit is used.
// [RL10] Control bits all zero mean the opportunity bit is data.
// [RL11] Control bits all one mean the opportunity bit is stuff.
// [RL12] Two comm bits per row are reachable on user ports.
// [RL13] Frames run as 9 rows of 90 bytes, row by row, 8000 per second.
// [RL14] The first three columns of each frame are transport overhead.
// [RL15] The envelope start comes from the pointer bytes.
// [RL16] The de-mapper votes three of five over the control bits.
// [RL17] A bit buffer above nominal fill takes data, else stuff.
`timescale 1ns/100ps
module dsm_mapper #(
    parameter int         DEPTH  = 64,     // Elastic buffer bits
    parameter logic [9:0] TX_PTR = 10'h000 // Outgoing envelope offset
) (
    input  wire logic       mclk,          // 250 MHz system clock
    input  wire logic       srst,          // Synchronous reset
    input  wire logic       ds3_in_bit,    // Incoming DS3 bit
    input  wire logic       ds3_in_valid,  // Incoming bit strobe
    output logic            ds3_in_ready,  // Buffer has room
    input  wire logic [1:0] oh_tx,         // Comm bits to send
    input  wire logic       tx_req,        // Frame logic wants a byte
    input  wire logic       tx_fs,         // Requested byte starts frame
    output logic [7:0]      tx_byte,       // Built byte
    output logic            tx_byte_valid, // Built byte strobe
    output logic            tx_underrun,   // Buffer ran dry
    input  wire logic [7:0] rx_byte,       // Received frame byte
    input  wire logic       rx_valid,      // Received byte strobe
    input  wire logic       rx_fs,         // Received byte starts frame
    output logic            ds3_out_bit,   // Recovered DS3 bit
    output logic            ds3_out_valid, // Recovered bit strobe
    output logic [1:0]      oh_rx          // Comm bits received
);
    import dsm_pkg::*;

    localparam int         AW      = $clog2(DEPTH);
    localparam logic [AW:0] FULL_LVL = (AW+1)'(DEPTH);
    localparam logic [AW:0] NOM_LVL  = (AW+1)'(DEPTH / 2);

    logic        mem [0:DEPTH-1];
    logic [AW:0] wp_reg;
    logic [AW:0] rp_reg;
    logic [AW:0] fill;
    logic        push;
    logic        pop_req;
    logic        pop;

    dsm_seq_t    tx_st;
    dsm_seq_t    rx_st;
    logic [2:0]  tx_cnt;
    logic [2:0]  rx_cnt;
    dsm_loc_t    tx_loc;
    dsm_loc_t    rx_loc;
    logic        tx_step;
    logic        rx_step;
    logic [9:0]  tx_p;
    logic [9:0]  rx_p;
    dsm_bit_t    tx_bk;
    dsm_bit_t    rx_bk;
    logic        tx_bits;
    logic        rx_bits;
    logic        tx_pay;
    logic        rx_pay;
    logic        tx_bit;
    logic        rx_b;
    logic        stuff_reg;
    logic        stuff_now;
    logic [7:0]  toh_byte;
    logic [7:0]  tx_sh;
    logic [7:0]  rx_sh;
    logic [7:0]  h1_reg;
    logic [9:0]  rx_ptr_reg;
    logic [2:0]  ones_reg;
    logic        rx_emit;

    // Elastic bit buffer; full only drops bits the source chose to send
    assign fill         = wp_reg - rp_reg;
    assign ds3_in_ready = fill != FULL_LVL;
    assign push         = ds3_in_valid && ds3_in_ready;
    assign pop          = pop_req && fill != '0;

    always_ff @(posedge mclk) begin
        if (push)
            mem[wp_reg[AW-1:0]] <= ds3_in_bit;
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            wp_reg <= '0;
            rp_reg <= '0;
        end else begin
            if (push)
                wp_reg <= wp_reg + 1'b1;
            if (pop)
                rp_reg <= rp_reg + 1'b1; // [RL17]
        end
    end

    // Byte slot trackers; requests while busy are ignored
    assign tx_step = tx_req && tx_st == SQ_IDLE;
    assign rx_step = rx_valid && rx_st == SQ_IDLE;

    dsm_track u_tx_track (
        .mclk (mclk),
        .srst (srst),
        .step (tx_step),
        .fs   (tx_fs),
        .ptr  (TX_PTR),
        .loc  (tx_loc)
    );

    dsm_track u_rx_track (
        .mclk (mclk),
        .srst (srst),
        .step (rx_step),
        .fs   (rx_fs),
        .ptr  (rx_ptr_reg),
        .loc  (rx_loc)
    );

    // Eight bit cycles follow each accepted byte slot
    always_ff @(posedge mclk) begin
        if (srst) begin
            tx_st  <= SQ_IDLE;
            tx_cnt <= 3'h0;
        end else begin
            case (tx_st)
                SQ_IDLE: if (tx_step) begin
                    tx_st  <= SQ_BITS;
                    tx_cnt <= 3'h0;
                end
                SQ_BITS: begin
                    tx_cnt <= tx_cnt + 3'h1;
                    if (tx_cnt == 3'h7)
                        tx_st <= SQ_IDLE;
                end
                default: tx_st <= SQ_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            rx_st  <= SQ_IDLE;
            rx_cnt <= 3'h0;
            rx_sh  <= 8'h00;
        end else begin
            case (rx_st)
                SQ_IDLE: if (rx_step) begin
                    rx_st  <= SQ_BITS;
                    rx_cnt <= 3'h0;
                    rx_sh  <= rx_byte;
                end
                SQ_BITS: begin
                    rx_cnt <= rx_cnt + 3'h1;
                    if (rx_cnt == 3'h7)
                        rx_st <= SQ_IDLE;
                end
                default: rx_st <= SQ_IDLE;
            endcase
        end
    end

    // Bit place in the row; column 0 is path overhead, never payload
    assign tx_bits = tx_st == SQ_BITS;
    assign rx_bits = rx_st == SQ_BITS;
    assign tx_pay  = !tx_loc.toh && tx_loc.spos.col != 7'h00; // [RL4]
    assign rx_pay  = !rx_loc.toh && rx_loc.spos.col != 7'h00; // [RL4]
    assign tx_p    = {tx_loc.spos.col - 7'h01, tx_cnt};
    assign rx_p    = {rx_loc.spos.col - 7'h01, rx_cnt};
    assign tx_bk   = bit_kind(tx_p); // [RL7]
    assign rx_bk   = bit_kind(rx_p); // [RL7]
    assign rx_b    = rx_sh[3'h7 - rx_cnt];

    // Outgoing overhead: only the pointer bytes carry content here
    always_comb begin
        if (tx_loc.fpos.row == PTR_ROW && tx_loc.fpos.col == H1_COL)
            toh_byte = {H1_FLAGS, TX_PTR[9:8]};            // [RL15]
        else if (tx_loc.fpos.row == PTR_ROW && tx_loc.fpos.col == H2_COL)
            toh_byte = TX_PTR[7:0];                        // [RL15]
        else
            toh_byte = 8'h00;                              // [RL14]
    end

    // Mapper bit choice; stuff decided once per row at first control bit
    always_comb begin
        stuff_now = stuff_reg;
        if (tx_pay && tx_p == CTL_FIRST)
            stuff_now = fill <= NOM_LVL;                   // [RL17] [RL8]
        pop_req = 1'b0;
        tx_bit  = 1'b0;
        if (tx_loc.toh) begin
            tx_bit = toh_byte[3'h7 - tx_cnt];
        end else if (tx_pay) begin
            case (tx_bk)
                BK_OHC:  tx_bit  = (tx_p == OH_FIRST) ? oh_tx[1] : oh_tx[0];
                BK_CTL:  tx_bit  = stuff_now;              // [RL10] [RL11]
                BK_SOPP: pop_req = !stuff_now & tx_bits;   // [RL10] [RL11]
                BK_DATA: pop_req = tx_bits;                // [RL6]
                default: tx_bit  = 1'b0;                   // [RL5]
            endcase
            if (pop_req)
                tx_bit = fill != '0 && mem[rp_reg[AW-1:0]];
        end
    end

    // Stuff choice holds for the rest of the row
    always_ff @(posedge mclk) begin
        if (srst)
            stuff_reg <= 1'b1;
        else if (tx_bits && tx_pay && tx_p == CTL_FIRST)
            stuff_reg <= stuff_now; // [RL9]
    end

    // Byte assembly, most significant bit first
    always_ff @(posedge mclk) begin
        if (srst) begin
            tx_sh         <= 8'h00;
            tx_byte       <= 8'h00;
            tx_byte_valid <= 1'b0;
            tx_underrun   <= 1'b0;
        end else begin
            tx_byte_valid <= 1'b0;
            tx_underrun   <= pop_req && fill == '0;
            if (tx_bits) begin
                tx_sh <= {tx_sh[6:0], tx_bit};
                if (tx_cnt == 3'h7) begin
                    tx_byte       <= {tx_sh[6:0], tx_bit};
                    tx_byte_valid <= 1'b1; // [RL13]
                end
            end
        end
    end

    // Pointer capture; out of range values are ignored
    always_ff @(posedge mclk) begin
        if (srst) begin
            h1_reg     <= 8'h00;
            rx_ptr_reg <= 10'h000;
        end else if (rx_bits && rx_cnt == 3'h0 && rx_loc.toh
                     && rx_loc.fpos.row == PTR_ROW) begin
            if (rx_loc.fpos.col == H1_COL)
                h1_reg <= rx_sh;
            else if (rx_loc.fpos.col == H2_COL
                     && {h1_reg[1:0], rx_sh} <= EC_LAST)
                rx_ptr_reg <= {h1_reg[1:0], rx_sh}; // [RL15]
        end
    end

    // De-mapper: majority vote tolerates one corrupted control bit
    assign rx_emit = rx_bits && rx_pay && (rx_bk == BK_DATA // [RL6]
                     || (rx_bk == BK_SOPP && ones_reg < CTL_MAJ)); // [RL16]

    always_ff @(posedge mclk) begin
        if (srst) begin
            ones_reg      <= 3'h0;
            ds3_out_bit   <= 1'b0;
            ds3_out_valid <= 1'b0;
            oh_rx         <= 2'b00;
        end else begin
            ds3_out_valid <= rx_emit;
            if (rx_emit)
                ds3_out_bit <= rx_b;
            if (rx_bits && rx_pay && rx_bk == BK_CTL)
                ones_reg <= (rx_p == CTL_FIRST) ? {2'b00, rx_b}
                            : ones_reg + {2'b00, rx_b};   // [RL9] [RL16]
            if (rx_bits && rx_pay && rx_bk == BK_OHC) begin
                if (rx_p == OH_FIRST)
                    oh_rx[1] <= rx_b;                     // [RL12]
                else
                    oh_rx[0] <= rx_b;                     // [RL12]
            end
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    sequence s_tx_start;
        tx_req && tx_st == SQ_IDLE;
    endsequence
    // Strobe launches at the eighth bit edge, so it is seen nine edges on
    sequence s_tx_done;
        !tx_byte_valid ##1 !tx_byte_valid [*8] ##1 tx_byte_valid;
    endsequence
    property p_byte_time;
        s_tx_start |-> s_tx_done;
    endproperty
    a_byte_time: assert property (p_byte_time) // [RL13]
        else $error("byte not ready nine cycles after request");

    property p_toh_idle;
        tx_bits && tx_loc.toh |-> !pop_req;
    endproperty
    a_toh_idle: assert property (p_toh_idle) // [RL14]
        else $error("data taken during overhead byte");

    property p_poh_zero;
        tx_bits && !tx_loc.toh && tx_loc.spos.col == 7'h00
            |-> !pop_req && !tx_bit;
    endproperty
    a_poh_zero: assert property (p_poh_zero) // [RL4]
        else $error("path overhead column used for payload");

    property p_fixed_stuff;
        tx_bits && tx_pay && tx_p < OH_FIRST |-> !tx_bit && !pop_req;
    endproperty
    a_fixed_stuff: assert property (p_fixed_stuff) // [RL5]
        else $error("fixed stuff bit not zero");

    property p_data_pop;
        tx_bits && tx_pay && tx_p > SO_POS |-> pop_req;
    endproperty
    a_data_pop: assert property (p_data_pop) // [RL6]
        else $error("data bit did not draw from buffer");

    property p_so_match;
        tx_bits && tx_pay && tx_p == SO_POS
            |-> $past(tx_bit) == stuff_reg && pop_req == !stuff_reg;
    endproperty
    a_so_match: assert property (p_so_match) // [RL10]
        else $error("opportunity bit disagrees with control bits");

    property p_stuff_rate;
        tx_bits && tx_pay && tx_p == CTL_FIRST
            |=> stuff_reg == ($past(fill) <= NOM_LVL);
    endproperty
    a_stuff_rate: assert property (p_stuff_rate) // [RL17]
        else $error("stuff choice ignores buffer fill");

    property p_vote_stuff;
        rx_bits && rx_pay && rx_bk == BK_SOPP && ones_reg >= CTL_MAJ
            |=> !ds3_out_valid;
    endproperty
    a_vote_stuff: assert property (p_vote_stuff) // [RL16]
        else $error("stuff bit passed to output");

    property p_vote_data;
        rx_bits && rx_pay && rx_bk == BK_SOPP && ones_reg < CTL_MAJ
            |=> ds3_out_valid && ds3_out_bit == $past(rx_b);
    endproperty
    a_vote_data: assert property (p_vote_data) // [RL16]
        else $error("opportunity data bit lost");
endmodule : dsm_mapper

// [dv/dsm_frm_model.sv]
// Frame-side model: paced byte requests and a loopback to the receiver
`timescale 1ns/100ps
module dsm_frm_model (
    input  wire logic       mclk,          // System clock
    input  wire logic       srst,          // Synchronous reset
    input  wire logic       hit_en,        // Corrupt one control bit a row
    output logic            tx_req,        // Byte request pulse
    output logic            tx_fs,         // Request is frame byte 0
    input  wire logic [7:0] tx_byte,       // Byte from the mapper
    input  wire logic       tx_byte_valid, // Byte strobe
    output logic [7:0]      rx_byte,       // Looped back byte
    output logic            rx_valid,      // Looped back strobe
    output logic            rx_fs,         // Looped byte is frame byte 0
    output logic [9:0]      bidx           // Frame index of byte in flight
);
    logic [3:0] gap_reg;

    // Eleven cycles a byte, so the index still names the byte in flight
    always_ff @(posedge mclk) begin
        if (srst) begin
            gap_reg <= 4'h0;
            tx_req  <= 1'b0;
            tx_fs   <= 1'b0;
            bidx    <= 10'h329;
        end else begin
            gap_reg <= (gap_reg == 4'hA) ? 4'h0 : gap_reg + 4'h1;
            tx_req  <= (gap_reg == 4'h0);
            tx_fs   <= (gap_reg == 4'h0) && (bidx == 10'h329);
            if (gap_reg == 4'h0)
                bidx <= (bidx == 10'h329) ? 10'h000 : bidx + 10'h001;
        end
    end

    // Loopback; an idle byte line flips each cycle, showing the inverse and the stale copy in turn
    always_ff @(posedge mclk) begin
        rx_valid <= tx_byte_valid && !srst;
        rx_fs    <= tx_byte_valid && (bidx == 10'h000);
        if (tx_byte_valid)
            rx_byte <= tx_byte ^ {hit_en && (bidx % 90 == 12), 7'h00};
        else
            rx_byte <= ~rx_byte;
    end
endmodule : dsm_frm_model

// [dv/tb_top.sv]
// Self-checking bench: mapper looped back through the frame model
`timescale 1ns/100ps
module tb_top;
    logic       mclk, srst, ds3_in_bit, ds3_in_valid, ds3_in_ready;
    logic       tx_req, tx_fs, tx_byte_valid, tx_underrun, hit_en;
    logic       rx_valid, rx_fs, ds3_out_bit, ds3_out_valid;
    logic [1:0] oh_tx, oh_rx;
    logic [7:0] tx_byte, rx_byte, c11;
    logic [9:0] bidx;
    logic [4:0] exp_ctl;
    logic       q[$];
    bit         feed_on, cmp_on, ctl_on, seen_full;
    int         n_fail, checks, cyc, n_out, n_under, n_sent, row, col;

    dsm_mapper #(.DEPTH(64), .TX_PTR(10'h000)) DUT (
        .mclk(mclk), .srst(srst), .ds3_in_bit(ds3_in_bit),
        .ds3_in_valid(ds3_in_valid), .ds3_in_ready(ds3_in_ready),
        .oh_tx(oh_tx), .tx_req(tx_req), .tx_fs(tx_fs), .tx_byte(tx_byte),
        .tx_byte_valid(tx_byte_valid), .tx_underrun(tx_underrun),
        .rx_byte(rx_byte), .rx_valid(rx_valid), .rx_fs(rx_fs),
        .ds3_out_bit(ds3_out_bit), .ds3_out_valid(ds3_out_valid),
        .oh_rx(oh_rx));

    dsm_frm_model u_frm (
        .mclk(mclk), .srst(srst), .hit_en(hit_en), .tx_req(tx_req),
        .tx_fs(tx_fs), .tx_byte(tx_byte), .tx_byte_valid(tx_byte_valid),
        .rx_byte(rx_byte), .rx_valid(rx_valid), .rx_fs(rx_fs),
        .bidx(bidx));

    task automatic check(input string what, input logic [15:0] exp,
                         input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : end_of_test

    // Settle just after the edge that starts a frame
    task automatic wait_fs;
        @(posedge mclk iff (tx_req && tx_fs));
        @(negedge mclk);
    endtask : wait_fs

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    // Hang guard, about six frames of eleven-cycle bytes plus margin
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 75000) begin
            n_fail++;
            end_of_test();
        end
    end

    // Source: offer a bit each cycle, keep the accepted ones in order
    always @(posedge mclk) begin
        if (ds3_in_valid && ds3_in_ready) begin
            q.push_back(ds3_in_bit);
            n_sent++;
        end
        if (!ds3_in_ready)
            seen_full = 1'b1;
        ds3_in_valid <= feed_on;
        ds3_in_bit   <= n_sent[0] ^ n_sent[4];
    end

    // Sink: recovered bits must match the source in order
    always @(posedge mclk) begin
        if (tx_underrun)
            n_under++;
        if (ds3_out_valid) begin
            n_out++;
            if (cmp_on)
                check("ds3 bit", q.size() ? q.pop_front() : 1'bx,
                      {15'h0000, ds3_out_bit});
        end
    end

    // Byte monitor; envelope column c sits in frame column c+3 at ptr 0
    always @(posedge mclk) begin
        if (tx_byte_valid) begin
            row = bidx / 90;
            col = bidx % 90;
            if (col < 3)
                check("overhead", (row == 3 && col == 0) ? 16'h0060
                      : 16'h0000, {8'h00, tx_byte});
            else if (col < 11)
                check("poh or stuff", 16'h0000,
                      {8'h00, tx_byte});
            else if (col == 11) begin
                check("comm", {14'h0000, oh_tx},
                      {11'h000, tx_byte[7:3]});
                c11 = tx_byte;
            end else if (col == 12 && ctl_on)
                check("control", {11'h000, exp_ctl},
                      {11'h0, c11[2:0], tx_byte[7:6]});
        end
    end

    task automatic t_reset;
        @(negedge mclk);
        check("ready", 16'h0001, {15'h0000, ds3_in_ready});
        check("out valid", 16'h0000, {15'h0000, ds3_out_valid});
        check("comm rx", 16'h0000, {14'h0000, oh_rx});
        $display("test reset done");
    endtask : t_reset

    // Fast source keeps the buffer full, so every opportunity is data
    task automatic t_steady;
        feed_on = 1'b1;
        wait_fs();
        exp_ctl = 5'h00;
        ctl_on  = 1'b1;
        wait_fs();
        check("seen full", 16'h0001, {15'h0000, seen_full});
        check("comm rx", 16'h0002, {14'h0000, oh_rx});
        $display("test steady done");
    endtask : t_steady

    // One control bit a row corrupted: the vote must still read data
    task automatic t_vote;
        @(posedge mclk);
        oh_tx  <= 2'b01;
        hit_en <= 1'b1;
        wait_fs();
        n_out = 0;
        wait_fs();
        check("bits per frame", 16'h15DE,
              n_out[15:0]);
        check("comm rx", 16'h0001, {14'h0000, oh_rx});
        $display("test vote done");
    endtask : t_vote

    // Source stops: buffer runs dry, rows turn to stuff, underrun shows
    task automatic t_starve;
        cmp_on  = 1'b0;
        feed_on = 1'b0;
        ctl_on  = 1'b0;
        n_under = 0;
        wait_fs();
        exp_ctl = 5'h1F;
        ctl_on  = 1'b1;
        wait_fs();
        n_out = 0;
        wait_fs();
        check("bits per frame", 16'h15D5,
              n_out[15:0]);
        check("underrun", 16'h0001, {15'h0000, n_under != 0});
        $display("test starve done");
    endtask : t_starve

    initial begin
        srst         = 1'b1;
        ds3_in_bit   = 1'b0;
        ds3_in_valid = 1'b0;
        oh_tx        = 2'b10;
        hit_en       = 1'b0;
        cmp_on       = 1'b1;
        repeat (4) @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
        t_reset();
        t_steady();
        t_vote();
        t_starve();
        end_of_test();
    end
endmodule : tb_top
